// >>> logic/lgc_pkg.sv
// Contract
// - Two term arrays, outputs registered once or twice (reg_sel)
// - Twelve inputs shared by eight product terms
// - Term uses 1-12 inputs, true or inverted
// - Each output ORs up to eight terms
// - Eight-bit ALU, one operation per cycle
// - Selectable ALU operation, compares and conditions
// - Four working registers reachable by bus
// - Accumulators feed and receive ALU, compare
// - Operand registers only feed ALU, compare
// - Four-byte queues load or capture datapath values
// - Queues carry bulk data to and from bus
// - Cell clock run and reset selection
// - Queue direction: bus-in or bus-out
// - Eight 16-bit config words, routed select
`default_nettype none
package lgc_pkg;
  localparam int LGC_DW       = 8;   // Datapath width
  localparam int LGC_Q_DEPTH  = 4;   // Bytes per queue
  localparam int LGC_CFG_N    = 8;   // Config words
  localparam int LGC_CFG_AW   = 3;   // Config word select width
  localparam int LGC_PT_IN    = 12;  // Array inputs
  localparam int LGC_PT_TERMS = 8;   // Product terms per array
  localparam int LGC_PT_OUTS  = 4;   // Outputs per array

  // ALU operations held in a config word
  typedef enum logic [2:0] {
    LGC_OP_INC  = 3'h0,
    LGC_OP_DEC  = 3'h1,
    LGC_OP_ADD  = 3'h2,
    LGC_OP_SUB  = 3'h3,
    LGC_OP_AND  = 3'h4,
    LGC_OP_OR   = 3'h5,
    LGC_OP_XOR  = 3'h6,
    LGC_OP_PASS = 3'h7
  } lgc_op_t;

  // Where the ALU result goes
  localparam logic [1:0] LGC_DEST_NONE = 2'h0;
  localparam logic [1:0] LGC_DEST_A0   = 2'h1;
  localparam logic [1:0] LGC_DEST_A1   = 2'h2;
  localparam logic [1:0] LGC_DEST_BOTH = 2'h3;

  // Compare pairings
  localparam logic [1:0] LGC_CMP_A0D0 = 2'h0;
  localparam logic [1:0] LGC_CMP_A1D1 = 2'h1;
  localparam logic [1:0] LGC_CMP_A0A1 = 2'h2;
  localparam logic [1:0] LGC_CMP_A0D1 = 2'h3;

  // Queue direction seen from the bus
  localparam logic LGC_Q_IN  = 1'b0;
  localparam logic LGC_Q_OUT = 1'b1;

  // Bus register select
  typedef enum logic [2:0] {
    LGC_REG_ACC0 = 3'h0,
    LGC_REG_ACC1 = 3'h1,
    LGC_REG_OPR0 = 3'h2,
    LGC_REG_OPR1 = 3'h3,
    LGC_REG_Q0   = 3'h4,
    LGC_REG_Q1   = 3'h5
  } lgc_reg_t;

  // One 16-bit dynamic config word
  typedef struct packed {
    logic [1:0] rsvd;      // Reserved, ignored
    logic [1:0] cmp_sel;   // Compare pairing
    logic       push_src;  // 0: ALU result, 1: accumulator
    logic       push_en;   // Push into output queues
    logic       pop_acc;   // Pop input queues into accumulators
    logic       pop_opr;   // Pop input queues into operand regs
    logic [1:0] dest;      // ALU destination
    logic [1:0] srcb;      // B: opr0, opr1, acc0, acc1
    logic       srca;      // A: acc0 or acc1
    lgc_op_t    op;        // ALU operation
  } lgc_cfg_word_t;

  // Static configuration of one term array
  typedef struct packed {
    logic [LGC_PT_TERMS-1:0][LGC_PT_IN-1:0]    t_mask;   // True-input use
    logic [LGC_PT_TERMS-1:0][LGC_PT_IN-1:0]    c_mask;   // Inverted-input use
    logic [LGC_PT_OUTS-1:0][LGC_PT_TERMS-1:0]  or_mask;  // Terms per output
    logic [LGC_PT_OUTS-1:0]                    reg_sel;  // 1: registered out
  } lgc_pta_cfg_t;

  // Datapath condition outputs
  typedef struct packed {
    logic eq;     // Compare equal
    logic lt;     // Compare less than (unsigned)
    logic zero;   // ALU result all zeros
    logic ones;   // ALU result all ones
    logic carry;  // ALU carry or borrow
  } lgc_cond_t;
endpackage
`default_nettype wire

// >>> logic/lgc_pt_array.sv
`timescale 1ns/1ps
`default_nettype none
// Twelve-input, eight-term, four-output sum-of-products array
module lgc_pt_array (
  input  wire logic                             i_ref_clk,
  input  wire logic                             i_rst_n,
  input  wire logic [lgc_pkg::LGC_PT_IN-1:0]    i_in,
  input  wire lgc_pkg::lgc_pta_cfg_t            i_cfg,
  output logic      [lgc_pkg::LGC_PT_OUTS-1:0]  o_out
);
  import lgc_pkg::*;

  logic [LGC_PT_TERMS-1:0] term;      // Product term values
  logic [LGC_PT_OUTS-1:0]  sum;       // Combinational sums
  logic [LGC_PT_OUTS-1:0]  macro;     // Macrocell flops
  logic [LGC_PT_OUTS-1:0]  next_macro;

  // Terms and sums; an unused term reads 0 so it cannot force an output high
  always_comb begin
    for (int t = 0; t < LGC_PT_TERMS; t++) begin
      term[t] = (|(i_cfg.t_mask[t] | i_cfg.c_mask[t]))
        && (&(~i_cfg.t_mask[t] | i_in))
        && (&(~i_cfg.c_mask[t] | ~i_in));
    end
    for (int o = 0; o < LGC_PT_OUTS; o++) begin
      sum[o] = |(term & i_cfg.or_mask[o]);
    end
    next_macro = sum;
  end

  // Macrocell registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      macro <= '0;
    end else begin
      macro <= next_macro;
    end
  end

  // Per-output choice between flop and raw sum
  assign o_out = (i_cfg.reg_sel & macro) | (~i_cfg.reg_sel & sum);

  chk_sum_or_terms: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_cfg.or_mask[0] == '0) |-> !sum[0])
    else $error("output with no terms is high");
endmodule
`default_nettype wire

// >>> logic/lgc_cell.sv
`timescale 1ns/1ps
`default_nettype none
// Configurable logic cell: two term arrays and an 8-bit datapath with queues
module lgc_cell #(
  parameter int Q_DEPTH = lgc_pkg::LGC_Q_DEPTH  // Bytes per queue
) (
  input  wire logic                             i_ref_clk,
  input  wire logic                             i_rst_n,
  input  wire logic                             i_route_rst,  // Reset from routing
  input  wire logic                             i_rst_sel,    // 1: honour routed reset
  input  wire logic                             i_route_en,   // Run level from routing
  input  wire logic                             i_run_sel,    // 1: gate by routed run
  input  wire logic [lgc_pkg::LGC_PT_IN-1:0]    i_pta0_in,
  input  wire logic [lgc_pkg::LGC_PT_IN-1:0]    i_pta1_in,
  input  wire lgc_pkg::lgc_pta_cfg_t            i_pta0_cfg,
  input  wire lgc_pkg::lgc_pta_cfg_t            i_pta1_cfg,
  output logic      [lgc_pkg::LGC_PT_OUTS-1:0]  o_pta0_out,
  output logic      [lgc_pkg::LGC_PT_OUTS-1:0]  o_pta1_out,
  input  wire logic                             i_cfg_we,
  input  wire logic [lgc_pkg::LGC_CFG_AW-1:0]   i_cfg_waddr,
  input  wire lgc_pkg::lgc_cfg_word_t           i_cfg_wdata,
  input  wire logic [lgc_pkg::LGC_CFG_AW-1:0]   i_cfg_sel,    // Routed word select
  input  wire logic [1:0]                       i_q_dir,      // Per queue direction
  input  wire logic                             i_bus_wr,
  input  wire logic                             i_bus_rd,
  input  wire lgc_pkg::lgc_reg_t                i_bus_reg,
  input  wire logic [lgc_pkg::LGC_DW-1:0]       i_bus_wdata,
  output logic      [lgc_pkg::LGC_DW-1:0]       o_bus_rdata,
  output logic                                  o_bus_rvalid,
  output lgc_pkg::lgc_cond_t                    o_cond,
  output logic      [1:0]                       o_q_empty,
  output logic      [1:0]                       o_q_full
);
  import lgc_pkg::*;

  localparam int CW = $clog2(Q_DEPTH + 1);   // Count width
  localparam int PW = $clog2(Q_DEPTH);       // Pointer width
  localparam logic [CW-1:0] Q_FULL = CW'(Q_DEPTH);
  localparam logic [PW-1:0] P_LAST = PW'(Q_DEPTH - 1);

  // Datapath state
  logic [1:0][LGC_DW-1:0]              acc, next_acc;     // Accumulators
  logic [1:0][LGC_DW-1:0]              opr, next_opr;     // Operand regs
  logic [1:0][Q_DEPTH-1:0][LGC_DW-1:0] q_mem, next_q_mem; // Queue storage
  logic [1:0][PW-1:0]                  q_rd, next_q_rd;
  logic [1:0][PW-1:0]                  q_wr, next_q_wr;
  logic [1:0][CW-1:0]                  q_cnt, next_q_cnt;
  lgc_cfg_word_t [LGC_CFG_N-1:0]       cfg_ram, next_cfg_ram;
  // Registered outputs
  logic [LGC_DW-1:0]                   next_rdata;
  logic                                next_rvalid;
  lgc_cond_t                           next_cond;
  logic [LGC_PT_OUTS-1:0]              pta0_raw, pta1_raw;
  // Working values
  lgc_cfg_word_t                       cw;                // Active word
  logic                                run, cell_clr;
  logic [LGC_DW-1:0]                   alu_a, alu_b, cmp_a, cmp_b;
  logic [LGC_DW:0]                     alu9;              // Result with carry
  logic [1:0]                          bus_push, bus_pop, dp_push, dp_pop;
  logic [1:0][LGC_DW-1:0]              q_head;

  // Both arrays share one module; each output registered once or twice, per reg_sel
  lgc_pt_array u_pta0 (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_in      (i_pta0_in),
    .i_cfg     (i_pta0_cfg),
    .o_out     (pta0_raw)
  );
  lgc_pt_array u_pta1 (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_in      (i_pta1_in),
    .i_cfg     (i_pta1_cfg),
    .o_out     (pta1_raw)
  );

  // Clock gating and reset selection folded into run and clear terms
  assign run      = !i_run_sel || i_route_en;
  assign cell_clr = i_rst_sel && i_route_rst;

  // Active config word chosen from routing each cycle
  assign cw = cfg_ram[i_cfg_sel];

  // ALU and compare operand selection
  always_comb begin
    alu_a = acc[cw.srca];
    alu_b = cw.srcb[1] ? acc[cw.srcb[0]] : opr[cw.srcb[0]];
    case (cw.op)
      LGC_OP_INC:  alu9 = {1'b0, alu_a} + 9'h001;
      LGC_OP_DEC:  alu9 = {1'b0, alu_a} - 9'h001;
      LGC_OP_ADD:  alu9 = {1'b0, alu_a} + {1'b0, alu_b};
      LGC_OP_SUB:  alu9 = {1'b0, alu_a} - {1'b0, alu_b};
      LGC_OP_AND:  alu9 = {1'b0, alu_a & alu_b};
      LGC_OP_OR:   alu9 = {1'b0, alu_a | alu_b};
      LGC_OP_XOR:  alu9 = {1'b0, alu_a ^ alu_b};
      LGC_OP_PASS: alu9 = {1'b0, alu_a};
      default:     alu9 = '0;
    endcase
    case (cw.cmp_sel)
      LGC_CMP_A0D0: begin cmp_a = acc[0]; cmp_b = opr[0]; end
      LGC_CMP_A1D1: begin cmp_a = acc[1]; cmp_b = opr[1]; end
      LGC_CMP_A0A1: begin cmp_a = acc[0]; cmp_b = acc[1]; end
      default:      begin cmp_a = acc[0]; cmp_b = opr[1]; end
    endcase
  end

  // Queue request qualification; refused requests touch nothing
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      q_head[k]   = q_mem[k][q_rd[k]];
      bus_push[k] = i_bus_wr && (i_bus_reg == lgc_reg_t'(LGC_REG_Q0 + k))
                    && (i_q_dir[k] == LGC_Q_IN) && (q_cnt[k] != Q_FULL);
      bus_pop[k]  = i_bus_rd && (i_bus_reg == lgc_reg_t'(LGC_REG_Q0 + k))
                    && (i_q_dir[k] == LGC_Q_OUT) && (q_cnt[k] != '0);
      dp_pop[k]   = run && !cell_clr && (cw.pop_opr || cw.pop_acc)
                    && (i_q_dir[k] == LGC_Q_IN) && (q_cnt[k] != '0);
      dp_push[k]  = run && !cell_clr && cw.push_en
                    && (i_q_dir[k] == LGC_Q_OUT) && (q_cnt[k] != Q_FULL);
    end
  end

  // Next state of the datapath, queues, config RAM and outputs
  always_comb begin
    next_acc     = acc;
    next_opr     = opr;
    next_q_mem   = q_mem;
    next_q_rd    = q_rd;
    next_q_wr    = q_wr;
    next_q_cnt   = q_cnt;
    next_cfg_ram = cfg_ram;
    next_rvalid  = i_bus_rd;
    next_rdata   = '0;
    next_cond    = '0;
    if (i_cfg_we) begin
      next_cfg_ram[i_cfg_waddr] = i_cfg_wdata;
    end
    // ALU writes accumulators only; operand regs are never a destination
    if (run) begin
      if (cw.dest == LGC_DEST_A0 || cw.dest == LGC_DEST_BOTH) begin
        next_acc[0] = alu9[LGC_DW-1:0];
      end
      if (cw.dest == LGC_DEST_A1 || cw.dest == LGC_DEST_BOTH) begin
        next_acc[1] = alu9[LGC_DW-1:0];
      end
    end
    for (int k = 0; k < 2; k++) begin
      // Queue pops load operand regs or accumulators over the ALU result
      if (dp_pop[k] && cw.pop_opr) begin
        next_opr[k] = q_head[k];
      end
      if (dp_pop[k] && cw.pop_acc) begin
        next_acc[k] = q_head[k];
      end
      // Direction keeps push and pop on opposite sides of each queue
      if (bus_push[k] || dp_push[k]) begin
        next_q_mem[k][q_wr[k]] = bus_push[k] ? i_bus_wdata
                               : (cw.push_src ? acc[k] : alu9[LGC_DW-1:0]);
        next_q_wr[k]  = (q_wr[k] == P_LAST) ? '0 : q_wr[k] + PW'(1);
        next_q_cnt[k] = q_cnt[k] + CW'(1);
      end
      // A push and a pop in one cycle leave the count as it was
      if (bus_pop[k] || dp_pop[k]) begin
        next_q_rd[k]  = (q_rd[k] == P_LAST) ? '0 : q_rd[k] + PW'(1);
        next_q_cnt[k] = next_q_cnt[k] - CW'(1);
      end
    end
    // Firmware writes win over datapath loads in the same cycle
    if (i_bus_wr) begin
      case (i_bus_reg)
        LGC_REG_ACC0: next_acc[0] = i_bus_wdata;
        LGC_REG_ACC1: next_acc[1] = i_bus_wdata;
        LGC_REG_OPR0: next_opr[0] = i_bus_wdata;
        LGC_REG_OPR1: next_opr[1] = i_bus_wdata;
        default:      ;
      endcase
    end
    if (i_bus_rd) begin
      case (i_bus_reg)
        LGC_REG_ACC0: next_rdata = acc[0];
        LGC_REG_ACC1: next_rdata = acc[1];
        LGC_REG_OPR0: next_rdata = opr[0];
        LGC_REG_OPR1: next_rdata = opr[1];
        LGC_REG_Q0:   next_rdata = bus_pop[0] ? q_head[0] : '0;
        LGC_REG_Q1:   next_rdata = bus_pop[1] ? q_head[1] : '0;
        default:      next_rdata = '0;
      endcase
    end
    // Conditions follow the active word even while halted
    next_cond.eq    = (cmp_a == cmp_b);
    next_cond.lt    = (cmp_a < cmp_b);
    next_cond.zero  = (alu9[LGC_DW-1:0] == '0);
    next_cond.ones  = (&alu9[LGC_DW-1:0]);
    next_cond.carry = alu9[LGC_DW];
    // Routed reset clears datapath state but keeps the config RAM
    if (cell_clr) begin
      next_acc   = '0;
      next_opr   = '0;
      next_q_rd  = '0;
      next_q_wr  = '0;
      next_q_cnt = '0;
    end
  end

  // Registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc          <= '0;
      opr          <= '0;
      q_mem        <= '0;
      q_rd         <= '0;
      q_wr         <= '0;
      q_cnt        <= '0;
      cfg_ram      <= '0;
      o_bus_rdata  <= '0;
      o_bus_rvalid <= 1'b0;
      o_cond       <= '0;
      o_q_empty    <= 2'h3;
      o_q_full     <= 2'h0;
      o_pta0_out   <= '0;
      o_pta1_out   <= '0;
    end else begin
      acc          <= next_acc;
      opr          <= next_opr;
      q_mem        <= next_q_mem;
      q_rd         <= next_q_rd;
      q_wr         <= next_q_wr;
      q_cnt        <= next_q_cnt;
      cfg_ram      <= next_cfg_ram;
      o_bus_rdata  <= next_rdata;
      o_bus_rvalid <= next_rvalid;
      o_cond       <= next_cond;
      o_q_empty    <= {next_q_cnt[1] == '0, next_q_cnt[0] == '0};
      o_q_full     <= {next_q_cnt[1] == Q_FULL, next_q_cnt[0] == Q_FULL};
      o_pta0_out   <= pta0_raw;
      o_pta1_out   <= pta1_raw;
    end
  end

  chk_q_count_bound: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    q_cnt[0] <= Q_FULL && q_cnt[1] <= Q_FULL)
    else $error("queue count beyond depth");

  chk_full_write_kept: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_bus_wr && i_bus_reg == LGC_REG_Q0 && q_cnt[0] == Q_FULL && !dp_pop[0] && !cell_clr
     && !bus_pop[0])
    |=> q_cnt[0] == Q_FULL && $stable(q_wr[0]) && $stable(q_mem[0]))
    else $error("write into full queue changed it");

  chk_empty_read_kept: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_bus_rd && i_bus_reg == LGC_REG_Q1 && q_cnt[1] == '0 && !dp_push[1]
     && !bus_push[1] && !cell_clr)
    |=> q_cnt[1] == '0 && $stable(q_rd[1]) && o_bus_rdata == '0)
    else $error("read of empty queue changed it");

  chk_alu_add_acc: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (run && !cell_clr && cw.op == LGC_OP_ADD && cw.dest == LGC_DEST_A1 && !cw.pop_acc
     && !(i_bus_wr && i_bus_reg == LGC_REG_ACC1))
    |=> acc[1] == $past(alu_a) + $past(alu_b))
    else $error("accumulator did not take the sum");

  chk_opr_no_alu: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!dp_pop[0] && !cell_clr && !(i_bus_wr && i_bus_reg == LGC_REG_OPR0)) |=> $stable(opr[0]))
    else $error("operand reg changed without load");

  chk_halt_hold: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!run && !cell_clr && !i_bus_wr && !i_bus_rd) |=> $stable(acc) && $stable(q_cnt))
    else $error("datapath moved while halted");

  chk_cmp_equal: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (cw.cmp_sel == LGC_CMP_A0D0 && acc[0] == opr[0]) |=> o_cond.eq && !o_cond.lt)
    else $error("equal compare not flagged");

  chk_bus_read_acc: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_bus_rd && i_bus_reg == LGC_REG_ACC1) |=> o_bus_rvalid && o_bus_rdata == $past(acc[1]))
    else $error("accumulator read wrong");

  chk_queue_order: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (bus_pop[0] && !dp_push[0] && !cell_clr)
    |=> o_bus_rdata == $past(q_head[0]) && q_cnt[0] == $past(q_cnt[0]) - CW'(1))
    else $error("queue read out of order");

  chk_pta_registered: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> o_pta1_out == $past(pta1_raw))
    else $error("array output not registered");
endmodule
`default_nettype wire

// >>> sim/lgc_bus_host.sv
`timescale 1ns/1ps
`default_nettype none
// Processor or DMA stand-in on the cell's byte-wide system bus
module lgc_bus_host (
  input  wire logic                  i_ref_clk,
  input  wire logic [7:0]            i_rdata,
  input  wire logic                  i_rvalid,
  output logic                       o_wr,
  output logic                       o_rd,
  output var lgc_pkg::lgc_reg_t      o_reg,
  output logic      [7:0]            o_wdata
);
  import lgc_pkg::*;

  // Idle bus from time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_reg = LGC_REG_ACC0;
    o_wdata = 8'h00;
  end

  // One-cycle write strobe; bulk data goes through the queues
  task automatic bus_write(input lgc_reg_t r, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_reg = r;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_ref_clk);
    o_wr = 1'b0;
    // Released data lines must not keep showing the byte just sent
    o_wdata = ~d;
  endtask

  // Read strobe for one cycle; the answer stands in the next cycle only
  task automatic bus_read(input lgc_reg_t r, output logic [7:0] d, output logic v);
    @(negedge i_ref_clk);
    o_reg = r;
    o_rd = 1'b1;
    @(negedge i_ref_clk);
    d = i_rdata;
    v = i_rvalid;
    o_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/programmable_logic_cell_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the logic cell
module programmable_logic_cell_tb;
  import lgc_pkg::*;

  // Table row: one bus register round trip beside one array case
  typedef struct {
    lgc_reg_t      breg;
    logic [7:0]    wd;
    logic [7:0]    rd;
    lgc_pta_cfg_t  cfg;
    logic [11:0]   pin;
    logic [3:0]    pout;
  } lgc_row_t;

  logic           ref_clk = 1'b0;   // 100 MHz
  logic           rst_n = 1'b0;     // Async reset, low active
  logic           route_rst = 1'b0;
  logic           rst_sel = 1'b0;
  logic           route_en = 1'b0;
  logic           run_sel = 1'b0;
  logic [11:0]    pta0_in = '0;
  logic [11:0]    pta1_in = '0;
  lgc_pta_cfg_t   pta0_cfg = '0;
  lgc_pta_cfg_t   pta1_cfg = '0;
  logic [3:0]     pta0_out;
  logic [3:0]     pta1_out;
  logic           cfg_we = 1'b0;
  logic [2:0]     cfg_waddr = '0;
  lgc_cfg_word_t  cfg_wdata = '0;
  logic [2:0]     cfg_sel = '0;     // Word 0 stays all zero: idle
  logic [1:0]     q_dir = '0;
  logic           bus_wr;
  logic           bus_rd;
  lgc_reg_t       bus_reg;
  logic [7:0]     bus_wdata;
  logic [7:0]     bus_rdata;
  logic           bus_rvalid;
  lgc_cond_t      cond;
  logic [1:0]     q_empty;
  logic [1:0]     q_full;
  int             err_total = 0;
  int             comparisons = 0;
  lgc_row_t       rows [5];

  // Free-running clock
  always #5 ref_clk = ~ref_clk;

  lgc_cell i_dut (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_route_rst(route_rst),
    .i_rst_sel(rst_sel), .i_route_en(route_en), .i_run_sel(run_sel),
    .i_pta0_in(pta0_in), .i_pta1_in(pta1_in), .i_pta0_cfg(pta0_cfg),
    .i_pta1_cfg(pta1_cfg), .o_pta0_out(pta0_out), .o_pta1_out(pta1_out),
    .i_cfg_we(cfg_we), .i_cfg_waddr(cfg_waddr), .i_cfg_wdata(cfg_wdata),
    .i_cfg_sel(cfg_sel), .i_q_dir(q_dir), .i_bus_wr(bus_wr), .i_bus_rd(bus_rd),
    .i_bus_reg(bus_reg), .i_bus_wdata(bus_wdata), .o_bus_rdata(bus_rdata),
    .o_bus_rvalid(bus_rvalid), .o_cond(cond), .o_q_empty(q_empty), .o_q_full(q_full)
  );

  lgc_bus_host i_host (
    .i_ref_clk(ref_clk), .i_rdata(bus_rdata), .i_rvalid(bus_rvalid),
    .o_wr(bus_wr), .o_rd(bus_rd), .o_reg(bus_reg), .o_wdata(bus_wdata)
  );

  // Verdict and end of run
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t flags %b, expected %b", $time, got, exp);
    end
  endtask

  // Bus read; a refused read still answers, with a zero byte
  task automatic rd_chk(input lgc_reg_t r, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_host.bus_read(r, d, v);
    chk_flags({3'h0, v}, 4'h1);
    chk_byte(d, exp);
  endtask

  task automatic cfg_wr(input logic [2:0] a, input lgc_cfg_word_t w);
    @(negedge ref_clk);
    cfg_we = 1'b1;
    cfg_waddr = a;
    cfg_wdata = w;
    @(negedge ref_clk);
    cfg_we = 1'b0;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Clear from routing; storage survives, pointers do not
  task automatic route_clear();
    rst_sel = 1'b1;
    route_rst = 1'b1;
    step(1);
    route_rst = 1'b0;
    rst_sel = 1'b0;
  endtask

  // Queue flags q: push_src, push_en, pop_acc, pop_opr; source A is acc0, B is opr0
  function automatic lgc_cfg_word_t mkw(input lgc_op_t op, input logic [1:0] dest,
                                        input logic [3:0] q);
    mkw = '0;
    mkw.op = op;
    mkw.dest = dest;
    {mkw.push_src, mkw.push_en, mkw.pop_acc, mkw.pop_opr} = q;
  endfunction

  function automatic logic [7:0] alu_exp(input lgc_op_t op, input logic [7:0] a,
                                         input logic [7:0] b);
    case (op)
      LGC_OP_INC: alu_exp = a + 8'h01;
      LGC_OP_DEC: alu_exp = a - 8'h01;
      LGC_OP_ADD: alu_exp = a + b;
      LGC_OP_SUB: alu_exp = a - b;
      LGC_OP_AND: alu_exp = a & b;
      LGC_OP_OR:  alu_exp = a | b;
      LGC_OP_XOR: alu_exp = a ^ b;
      default:    alu_exp = a;
    endcase
  endfunction

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #200000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end

  // Main sequence
  initial begin
    lgc_pta_cfg_t ca;
    lgc_pta_cfg_t cb;
    ca = '0;
    ca.t_mask[0] = 12'h801;
    ca.c_mask[0] = 12'h020;
    ca.or_mask[0] = 8'h01;
    cb = '0;
    for (int k = 0; k < 8; k++) begin
      cb.t_mask[k] = 12'h001 << k;
    end
    cb.or_mask[3] = 8'hFF;
    cb.or_mask[2] = 8'h08;
    cb.reg_sel = 4'hF;
    rows[0] = '{LGC_REG_ACC0, 8'hA5, 8'hA5, ca, 12'hFDF, 4'h1};
    rows[1] = '{LGC_REG_ACC1, 8'h3C, 8'h3C, ca, 12'hFFF, 4'h0};
    rows[2] = '{LGC_REG_OPR0, 8'h0F, 8'h0F, cb, 12'h080, 4'h8};
    rows[3] = '{LGC_REG_OPR1, 8'hF0, 8'hF0, cb, 12'h008, 4'hC};
    rows[4] = '{LGC_REG_Q0,   8'h11, 8'h00, cb, 12'h000, 4'h0};
    step(8);
    chk_flags({q_empty, q_full}, 4'hC);
    chk_byte(bus_rdata, 8'h00);
    rst_n = 1'b1;
    // Ordinary cases: register round trip and array outputs
    foreach (rows[i]) begin
      pta0_cfg = rows[i].cfg;
      pta1_cfg = rows[i].cfg;
      pta0_in = rows[i].pin;
      pta1_in = rows[i].pin;
      i_host.bus_write(rows[i].breg, rows[i].wd);
      rd_chk(rows[i].breg, rows[i].rd);
      chk_flags(pta0_out, rows[i].pout);
      chk_flags(pta1_out, rows[i].pout);
    end
    // Conditions: equal operands, increment wraps to zero
    i_host.bus_write(LGC_REG_ACC0, 8'hFF);
    i_host.bus_write(LGC_REG_OPR0, 8'hFF);
    step(2);
    chk_flags({cond.eq, cond.lt, cond.zero, cond.ones}, 4'hA);
    chk_flags({3'h0, cond.carry}, 4'h1);
    // Every ALU operation once, one cycle each, result into acc1
    i_host.bus_write(LGC_REG_ACC0, 8'hC5);
    i_host.bus_write(LGC_REG_OPR0, 8'h3A);
    for (int k = 0; k < 8; k++) begin
      cfg_wr(3'h1, mkw(lgc_op_t'(k), LGC_DEST_A1, 4'h0));
      cfg_sel = 3'h1;
      step(1);
      cfg_sel = 3'h0;
      rd_chk(LGC_REG_ACC1, alu_exp(lgc_op_t'(k), 8'hC5, 8'h3A));
    end
    rd_chk(LGC_REG_ACC0, 8'hC5);
    rd_chk(LGC_REG_OPR0, 8'h3A);
    // Output queues: run gating, pushes of ALU results past full
    route_clear();
    rd_chk(LGC_REG_ACC0, 8'h00);
    chk_flags({q_empty, q_full}, 4'hC);
    i_host.bus_write(LGC_REG_ACC0, 8'h21);
    q_dir = 2'h3;
    cfg_wr(3'h2, mkw(LGC_OP_INC, LGC_DEST_A0, 4'h4));
    run_sel = 1'b1;
    cfg_sel = 3'h2;
    step(3);
    chk_flags({q_empty, q_full}, 4'hC);
    route_en = 1'b1;
    step(5);
    route_en = 1'b0;
    cfg_sel = 3'h0;
    chk_flags({q_empty, q_full}, 4'h3);
    for (int k = 0; k < 4; k++) begin
      rd_chk(LGC_REG_Q1, 8'h22 + 8'(k));
    end
    rd_chk(LGC_REG_Q1, 8'h00);
    rd_chk(LGC_REG_Q0, 8'h22);
    i_host.bus_write(LGC_REG_Q0, 8'h99);
    rd_chk(LGC_REG_Q0, 8'h23);
    chk_flags({q_empty, q_full}, 4'h8);
    rd_chk(LGC_REG_ACC0, 8'h26);
    // Input queues: overfill, then pop into operand regs and accumulators
    run_sel = 1'b0;
    q_dir = 2'h0;
    route_clear();
    for (int k = 0; k < 5; k++) begin
      i_host.bus_write(LGC_REG_Q0, 8'(16 * (k + 1)));
    end
    i_host.bus_write(LGC_REG_Q1, 8'h33);
    chk_flags({q_empty, q_full}, 4'h1);
    cfg_wr(3'h3, mkw(LGC_OP_INC, LGC_DEST_NONE, 4'h1));
    cfg_wr(3'h4, mkw(LGC_OP_INC, LGC_DEST_NONE, 4'h2));
    cfg_sel = 3'h3;
    step(1);
    cfg_sel = 3'h4;
    step(3);
    cfg_sel = 3'h0;
    rd_chk(LGC_REG_OPR0, 8'h10);
    rd_chk(LGC_REG_OPR1, 8'h33);
    rd_chk(LGC_REG_ACC0, 8'h40);
    rd_chk(LGC_REG_ACC1, 8'h00);
    chk_flags({q_empty, q_full}, 4'hC);
    // Mid-run reset: a queued byte and the accumulators are dropped
    i_host.bus_write(LGC_REG_Q0, 8'h5A);
    chk_flags({q_empty, q_full}, 4'h8);
    rst_n = 1'b0;
    step(2);
    chk_flags({q_empty, q_full}, 4'hC);
    rst_n = 1'b1;
    rd_chk(LGC_REG_ACC0, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
